// file: common/pie_params.svh
`ifndef PIE_PARAMS_SVH
`define PIE_PARAMS_SVH

// Byte offsets on the register bus.
`define PIE_OFS_EN_ONE 6'h00
`define PIE_OFS_EN_TWO 6'h04
`define PIE_OFS_EN_THREE 6'h08
`define PIE_OFS_REQ_ONE 6'h0c
`define PIE_OFS_REQ_TWO 6'h10
`define PIE_OFS_REQ_THREE 6'h14
`define PIE_OFS_CORE 6'h18

// Register indices (byte offset divided by four).
`define PIE_IDX_EN_ONE 3'h0
`define PIE_IDX_EN_TWO 3'h1
`define PIE_IDX_EN_THREE 3'h2
`define PIE_IDX_REQ_ONE 3'h3
`define PIE_IDX_REQ_TWO 3'h4
`define PIE_IDX_REQ_THREE 3'h5
`define PIE_IDX_CORE 3'h6
`define PIE_IDX_NONE 3'h7

// Implemented bits of each bank.
`define PIE_IMPL_ONE 8'hff
`define PIE_IMPL_TWO_LARGE 8'hf9
`define PIE_IMPL_TWO_SMALL 8'hb9
`define PIE_IMPL_THREE 8'h3a
`define PIE_C2_BIT 6

// Core interrupt control fields.
`define PIE_GLOBAL_EN_BIT 7
`define PIE_MASTER_EN_BIT 6
`define PIE_CORE_MASK 8'hc0

// Reset values.
`define PIE_RST_BYTE 8'h00
`define PIE_RST_WORD 32'h0000_0000

`endif

// file: common/pie_pkg.sv
package pie_pkg;

    typedef enum logic [1:0] {
        PIE_IDLE = 2'b00,
        PIE_ACK = 2'b01
    } pie_state_t;

    typedef logic [7:0] pie_byte_t;

endpackage

// file: logic/pie_ctrl.sv
// The Avalon-MM register port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "pie_params.svh"

module pie_ctrl #(
    parameter bit LARGE_PKG = 1'b1
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic [5:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    input wire pie_pkg::pie_byte_t EVT_ONE_I,
    input wire pie_pkg::pie_byte_t EVT_TWO_I,
    input wire pie_pkg::pie_byte_t EVT_THREE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    output logic PERIPH_IRQ_O,
    output logic IRQ_O
);
    import pie_pkg::*;

    // Bank two keeps the comparator two enable only on the larger variant.
    localparam pie_byte_t TWO_IMPL = LARGE_PKG ? `PIE_IMPL_TWO_LARGE : `PIE_IMPL_TWO_SMALL;

    pie_state_t state_q;
    pie_state_t state_d;
    logic [7:0] en_q [0:2];
    logic [7:0] flag_q [0:2];
    logic [7:0] evt [0:2];
    logic [2:0] pend;
    logic [7:0] core_q;
    logic [2:0] idx;
    logic wr_commit;
    logic [31:0] rdata_d;
    logic periph_d;
    logic irq_d;

    function automatic logic [2:0] reg_sel(input logic [5:0] addr);
        logic [2:0] sel;
        sel = `PIE_IDX_NONE;
        if (addr[1:0] == 2'h0 && addr[5] == 1'b0 && addr[4:2] != `PIE_IDX_NONE) begin
            sel = addr[4:2];
        end
        return sel;
    endfunction

    function automatic logic [7:0] impl_mask(input logic [1:0] bank);
        logic [7:0] m;
        m = `PIE_RST_BYTE;
        case (bank)
            2'h0: begin
                m = `PIE_IMPL_ONE;
            end
            2'h1: begin
                m = LARGE_PKG ? `PIE_IMPL_TWO_LARGE : `PIE_IMPL_TWO_SMALL;
            end
            2'h2: begin
                m = `PIE_IMPL_THREE;
            end
            default: begin
                m = `PIE_RST_BYTE;
            end
        endcase
        return m;
    endfunction

    assign idx = reg_sel(AVS_ADDRESS_I);
    assign evt[0] = EVT_ONE_I;
    assign evt[1] = EVT_TWO_I;
    assign evt[2] = EVT_THREE_I;

    // A write lands only at the edge where the master sees waitrequest low.
    assign wr_commit = (state_q == PIE_ACK) && AVS_WRITE_I && AVS_BYTEENABLE_I[0];

    always_comb begin
        state_d = state_q;
        case (state_q)
            PIE_IDLE: begin
                if (AVS_READ_I || AVS_WRITE_I) begin
                    state_d = PIE_ACK;
                end
            end
            PIE_ACK: begin
                state_d = PIE_IDLE;
            end
            default: begin
                state_d = PIE_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_q <= PIE_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            AVS_WAITREQUEST_O <= 1'b1;
        end else begin
            AVS_WAITREQUEST_O <= !(state_q == PIE_IDLE && (AVS_READ_I || AVS_WRITE_I));
        end
    end

    // Unmapped addresses read as zero, and reserved bits are never stored.
    always_comb begin
        rdata_d = `PIE_RST_WORD;
        case (idx)
            `PIE_IDX_EN_ONE: begin
                rdata_d[7:0] = en_q[0];
            end
            `PIE_IDX_EN_TWO: begin
                rdata_d[7:0] = en_q[1];
            end
            `PIE_IDX_EN_THREE: begin
                rdata_d[7:0] = en_q[2];
            end
            `PIE_IDX_REQ_ONE: begin
                rdata_d[7:0] = flag_q[0];
            end
            `PIE_IDX_REQ_TWO: begin
                rdata_d[7:0] = flag_q[1];
            end
            `PIE_IDX_REQ_THREE: begin
                rdata_d[7:0] = flag_q[2];
            end
            `PIE_IDX_CORE: begin
                rdata_d[7:0] = core_q;
            end
            default: begin
                rdata_d = `PIE_RST_WORD;
            end
        endcase
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            AVS_READDATA_O <= `PIE_RST_WORD;
        end else if (state_q == PIE_IDLE && AVS_READ_I) begin
            AVS_READDATA_O <= rdata_d;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_bank
            always_ff @(posedge CLK_I or posedge RST_I) begin
                if (RST_I) begin
                    en_q[g] <= `PIE_RST_BYTE;
                end else if (wr_commit && idx == 3'(`PIE_IDX_EN_ONE + g)) begin
                    en_q[g] <= AVS_WRITEDATA_I[7:0] & impl_mask(2'(g));
                end
            end

            // An event in the same cycle as a write-one clear keeps the flag set.
            always_ff @(posedge CLK_I or posedge RST_I) begin
                if (RST_I) begin
                    flag_q[g] <= `PIE_RST_BYTE;
                end else if (wr_commit && idx == 3'(`PIE_IDX_REQ_ONE + g)) begin
                    flag_q[g] <= (flag_q[g] & ~AVS_WRITEDATA_I[7:0]) | (evt[g] & impl_mask(2'(g)));
                end else begin
                    flag_q[g] <= flag_q[g] | (evt[g] & impl_mask(2'(g)));
                end
            end

            assign pend[g] = |(flag_q[g] & en_q[g]);
        end
    endgenerate

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            core_q <= `PIE_RST_BYTE;
        end else if (wr_commit && idx == `PIE_IDX_CORE) begin
            core_q <= AVS_WRITEDATA_I[7:0] & `PIE_CORE_MASK;
        end
    end

    // Flags stay sticky, so anything pending while disabled fires on re-enable.
    assign periph_d = core_q[`PIE_MASTER_EN_BIT] && (|pend);
    assign irq_d = core_q[`PIE_GLOBAL_EN_BIT] && periph_d;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            PERIPH_IRQ_O <= 1'b0;
            IRQ_O <= 1'b0;
        end else begin
            PERIPH_IRQ_O <= periph_d;
            IRQ_O <= irq_d;
        end
    end

    sequence req_start_s;
        (state_q == PIE_IDLE) && (AVS_READ_I || AVS_WRITE_I);
    endsequence

    sequence ack_pulse_s;
        !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O;
    endsequence

    sequence en_one_write_s;
        wr_commit && idx == `PIE_IDX_EN_ONE;
    endsequence

    // The enable and bank one request write steps are named once so that the checks below share one meaning of a commit.
    sequence en_two_write_s;
        wr_commit && idx == `PIE_IDX_EN_TWO;
    endsequence

    sequence en_three_write_s;
        wr_commit && idx == `PIE_IDX_EN_THREE;
    endsequence

    sequence req_one_write_s;
        wr_commit && idx == `PIE_IDX_REQ_ONE;
    endsequence

    sequence read_start_s;
        (state_q == PIE_IDLE) && AVS_READ_I;
    endsequence

    bus_ack_timing_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        req_start_s |=> ack_pulse_s)
        else $error("waitrequest did not drop for exactly one cycle");

    en_one_write_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        en_one_write_s |=> en_q[0] == $past(AVS_WRITEDATA_I[7:0]))
        else $error("enable bank one did not take the written byte");

    enable_gates_req_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        PERIPH_IRQ_O |-> $past(|pend))
        else $error("peripheral request without an enabled flag");

    reset_clears_en_a: assert property (@(posedge CLK_I)
        $fell(RST_I) |-> (en_q[0] == 8'h00 && en_q[1] == 8'h00 && en_q[2] == 8'h00))
        else $error("enable bits not zero after reset");

    bank_two_bits_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (wr_commit && idx == `PIE_IDX_EN_TWO && AVS_WRITEDATA_I[7:0] == 8'hff)
        |=> en_q[1][7] && en_q[1][5] && en_q[1][3] && en_q[1][0])
        else $error("bank two writable enable did not store");

    comp_two_variant_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        en_two_write_s
        |=> en_q[1][`PIE_C2_BIT] == (LARGE_PKG && $past(AVS_WRITEDATA_I[`PIE_C2_BIT])))
        else $error("comparator two enable does not follow the variant");

    two_reserved_zero_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        en_q[1][2:1] == 2'h0 && flag_q[1][2:1] == 2'h0)
        else $error("bank two reserved bits not zero");

    three_reserved_zero_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (en_q[2] & ~`PIE_IMPL_THREE) == 8'h00)
        else $error("bank three reserved bits not zero");

    master_gate_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        !core_q[`PIE_MASTER_EN_BIT] |=> !PERIPH_IRQ_O)
        else $error("peripheral request passed without master enable");

    flag_set_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (EVT_ONE_I[0] ##0 1'b1) |=> flag_q[0][0])
        else $error("event did not set its request flag");

    global_gate_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        IRQ_O |-> $past(core_q[`PIE_GLOBAL_EN_BIT]) && PERIPH_IRQ_O)
        else $error("interrupt passed while global enable clear");

    periph_req_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (core_q[`PIE_MASTER_EN_BIT] && |pend) |=> PERIPH_IRQ_O)
        else $error("pending enabled request not raised");

    two_write_mask_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        en_two_write_s |=> en_q[1] == ($past(AVS_WRITEDATA_I[7:0]) & TWO_IMPL))
        else $error("bank two stored a bit it does not implement");

    three_write_mask_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        en_three_write_s |=> en_q[2] == ($past(AVS_WRITEDATA_I[7:0]) & `PIE_IMPL_THREE))
        else $error("bank three stored a bit it does not implement");

    // A clear with no event in the same cycle must drop exactly the written ones.
    flag_clear_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (req_one_write_s ##0 (EVT_ONE_I == 8'h00))
        |=> flag_q[0] == ($past(flag_q[0]) & ~$past(AVS_WRITEDATA_I[7:0])))
        else $error("write of ones did not clear request flags");

    // Flags and outputs must also be clean, or a stale request would fire after reset.
    reset_clears_all_a: assert property (@(posedge CLK_I)
        $fell(RST_I) |-> (flag_q[0] == 8'h00 && flag_q[1] == 8'h00 && flag_q[2] == 8'h00
            && core_q == 8'h00 && !PERIPH_IRQ_O && !IRQ_O && AVS_WAITREQUEST_O))
        else $error("state not cleared by reset");

    global_block_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        !core_q[`PIE_GLOBAL_EN_BIT] |=> !IRQ_O)
        else $error("interrupt raised while global enable clear");

    global_serve_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (core_q[`PIE_GLOBAL_EN_BIT] && core_q[`PIE_MASTER_EN_BIT] && |pend) |=> IRQ_O)
        else $error("pending request not served under global enable");

    byte_lane_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (state_q == PIE_ACK && AVS_WRITE_I && !AVS_BYTEENABLE_I[0])
        |=> en_q[0] == $past(en_q[0]) && en_q[1] == $past(en_q[1])
            && en_q[2] == $past(en_q[2]))
        else $error("write without low byte lane changed an enable");

    read_stands_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        !(state_q == PIE_IDLE && AVS_READ_I) |=> $stable(AVS_READDATA_O))
        else $error("read data moved without a read");

    read_upper_zero_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        read_start_s |=> AVS_READDATA_O[31:8] == 24'h000000)
        else $error("read data upper bytes not zero");

    unmapped_read_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (read_start_s ##0 (idx == `PIE_IDX_NONE)) |=> AVS_READDATA_O == `PIE_RST_WORD)
        else $error("unmapped address returned data");

    en_one_read_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (read_start_s ##0 (idx == `PIE_IDX_EN_ONE)) |=> AVS_READDATA_O[7:0] == $past(en_q[0]))
        else $error("enable bank one read back wrong");

    ack_state_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        !AVS_WAITREQUEST_O |-> state_q == PIE_ACK)
        else $error("waitrequest low outside an acknowledge");

endmodule

`default_nettype wire

// file: bench/pie_evt_src.sv
`timescale 1ns/10ps
`default_nettype none

module pie_evt_src (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic fire_i,
    input wire logic [23:0] pat_i,
    output pie_pkg::pie_byte_t evt_one_o,
    output pie_pkg::pie_byte_t evt_two_o,
    output pie_pkg::pie_byte_t evt_three_o
);
    import pie_pkg::*;

    // Each event follows fire_i one cycle later, so a one-cycle fire sets each flag selected by pat_i once.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            {evt_three_o, evt_two_o, evt_one_o} <= 24'h000000;
        end else begin
            {evt_three_o, evt_two_o, evt_one_o} <= fire_i ? pat_i : 24'h000000;
        end
    end
endmodule

`default_nettype wire

// file: bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "pie_params.svh"

module tb_top;
    import pie_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] adr = 6'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [3:0] be = 4'hf;
    logic fire = 1'b0;
    logic [23:0] pat = 24'h0;
    pie_byte_t e1, e2, e3;
    logic [31:0] rdat;
    logic wreq, pirq, irq;
    logic [7:0] msk [3] = '{`PIE_IMPL_ONE, `PIE_IMPL_TWO_LARGE, `PIE_IMPL_THREE};
    int err_total = 0;
    int checks = 0;

    always #25 clk = ~clk;

    pie_evt_src pie_evt_src_i (.clk_i(clk), .rst_i(rst), .fire_i(fire), .pat_i(pat),
        .evt_one_o(e1), .evt_two_o(e2), .evt_three_o(e3));

    pie_ctrl #(.LARGE_PKG(1'b1)) pie_ctrl_i (.CLK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(adr),
        .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(be),
        .EVT_ONE_I(e1), .EVT_TWO_I(e2), .EVT_THREE_I(e3), .AVS_READDATA_O(rdat),
        .AVS_WAITREQUEST_O(wreq), .PERIPH_IRQ_O(pirq), .IRQ_O(irq));

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // The request is held until waitrequest is seen low, then released.
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        rd <= ~w;
        wr <= w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 20) chk(32'h1, 32'h0);
        @(posedge clk);
    endtask

    task automatic wr_r(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic chk_r(input logic [5:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask

    task automatic fire_ev(input logic [23:0] p);
        pat <= p;
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        tick(3);
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        tick(8);
        rst <= 1'b0;
        tick(1);
        for (int i = 0; i < 3; i++) chk_r(6'(i * 4), 32'h0);
        $display("test reset values done");
        for (int i = 0; i < 3; i++) begin
            wr_r(6'(i * 4), 32'hffffffff);
            chk_r(6'(i * 4), {24'h0, msk[i]});
        end
        wr_r(6'h1c, 32'hff);
        chk_r(6'h1c, 32'h0);
        be <= 4'he;
        wr_r(`PIE_OFS_EN_ONE, 32'h0);
        be <= 4'hf;
        chk_r(`PIE_OFS_EN_ONE, 32'hff);
        $display("test register access done");
        fire_ev(24'hffffff);
        for (int i = 0; i < 3; i++) chk_r(6'(12 + i * 4), {24'h0, msk[i]});
        chk({31'h0, pirq}, 32'h0);
        wr_r(`PIE_OFS_CORE, 32'h40);
        tick(2);
        chk({31'h0, pirq}, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr_r(`PIE_OFS_CORE, 32'hc0);
        tick(2);
        chk({31'h0, irq}, 32'h1);
        for (int i = 0; i < 3; i++) wr_r(6'(12 + i * 4), 32'hff);
        tick(2);
        chk({31'h0, pirq}, 32'h0);
        $display("test gating done");
        // Walk every bit: a blocked flag must stay silent until its own enable is set.
        for (int i = 0; i < 3; i++) begin
            for (int b = 0; b < 8; b++) begin
                wr_r(6'(i * 4), {24'h0, ~(8'h01 << b)});
                fire_ev(24'h000001 << (i * 8 + b));
                chk({31'h0, pirq}, 32'h0);
                wr_r(6'(i * 4), {24'h0, 8'h01 << b});
                tick(2);
                chk({31'h0, pirq}, {31'h0, msk[i][b]});
                chk({31'h0, irq}, {31'h0, msk[i][b]});
                wr_r(6'(12 + i * 4), {24'h0, 8'h01 << b});
                tick(2);
                chk({31'h0, pirq}, 32'h0);
            end
        end
        $display("test bit walk done");
        wr_r(`PIE_OFS_CORE, 32'h80);
        wr_r(`PIE_OFS_EN_ONE, 32'hff);
        fire_ev(24'h0000ff);
        tick(2);
        chk({31'h0, pirq}, 32'h0);
        chk({31'h0, irq}, 32'h0);
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        tick(1);
        for (int i = 0; i < 3; i++) chk_r(6'(i * 4), 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("test master enable and reset done");
        test_done;
    end

    initial begin
        #1000000;
        err_total++;
        test_done;
    end
endmodule

`default_nettype wire
